// ==== rpls_regs.sv ====
// Configuration register bank for one root port: lane split, error injection,
// completion-timeout sub-range. Assumes single-cycle config read/write strobes.
`default_nettype none
module rpls_regs #(
  parameter bit HOST_LINK_PORT = 1'b0,
  parameter bit WIDE_PORT = 1'b1,
  // Arbitrary neutral value for the vendor-specific id
  parameter logic [15:0] VSEC_ID = 16'h00a5
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sticky_rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic cto_err_in,
  input wire logic rcv_err_in,
  input wire logic host_ack_in,
  output logic cto_err_out,
  output logic rcv_err_out,
  output logic bif_start,
  output logic [2:0] bif_split,
  output rpls_pkg::rpls_width_type [3:0] quad_width,
  output logic [1:0] cto_subrange,
  output logic host_ctrl_en
);
  import rpls_pkg::*;

  logic [2:0] split_r;
  logic [2:0] split_nxt;
  logic start_r;
  logic reset_bif_r;
  logic inj_dis_r;
  logic inj_dis_done_r;
  logic inj_cto_r;
  logic inj_rcv_r;
  logic cto_pulse_r;
  logic rcv_pulse_r;
  logic [1:0] cto_sel_r;
  logic host_en_r;
  logic host_ack_r;
  logic ack_s1_r;
  logic ack_s2_r;
  logic [31:0] rdata_r;
  logic rvalid_r;
  logic [31:0] rd_mux;
  rpls_width_type [3:0] qw_r;
  rpls_width_type [3:0] qw_nxt;

  wire wr_split = cfg_wr && cfg_addr == OFS_LANE_SPLIT && cfg_be[0];
  wire wr_inj = cfg_wr && cfg_addr == OFS_INJ_CTRL && cfg_be[0];
  wire wr_cto = cfg_wr && cfg_addr == OFS_CTO_CTRL && cfg_be[1];
  wire wr_hctl = cfg_wr && cfg_addr == OFS_HOST_CTRL && cfg_be[0] && HOST_LINK_PORT;
  wire wr_hsts = cfg_wr && cfg_addr == OFS_HOST_STAT && cfg_be[0] && HOST_LINK_PORT;
  wire new_cto = cfg_wdata[INJ_CTO_BIT];
  wire new_rcv = cfg_wdata[INJ_RCV_BIT];
  wire [2:0] split_wval = HOST_LINK_PORT ? 3'h0 : cfg_wdata[SPLIT_W-1:0];

  assign split_nxt = wr_split ? split_wval : split_r;
  always_ff @(posedge clk) begin
    if (sticky_rst) begin
      split_r <= HOST_LINK_PORT ? 3'h0 : SPLIT_RST;
    end else begin
      split_r <= split_nxt;
    end
  end

  // Start pulse from write of one
  always_ff @(posedge clk) begin
    if (srst) begin
      start_r <= 1'b0;
      reset_bif_r <= 1'b1;
    end else begin
      start_r <= wr_split && cfg_wdata[START_BIT] && !HOST_LINK_PORT;
      reset_bif_r <= 1'b0;
    end
  end

  assign bif_start = start_r || reset_bif_r;
  // New split value already in split_r when start pulses
  assign bif_split = split_r;

  always_comb begin
    qw_nxt = '{LW_OFF, LW_OFF, LW_OFF, LW_OFF};
    if (!WIDE_PORT) begin
      unique case (split_r)
        SPL8_4X4: qw_nxt = '{LW_OFF, LW_OFF, LW_X4, LW_X4};
        SPL8_8: qw_nxt = '{LW_OFF, LW_OFF, LW_OFF, LW_X8};
        default: qw_nxt = '{LW_OFF, LW_OFF, LW_OFF, LW_OFF};
      endcase
    end else begin
      unique case (split_r)
        SPL_4X4X4X4: qw_nxt = '{LW_X4, LW_X4, LW_X4, LW_X4};
        SPL_4X4X8: qw_nxt = '{LW_X4, LW_X4, LW_OFF, LW_X8};
        SPL_8X4X4: qw_nxt = '{LW_OFF, LW_X8, LW_X4, LW_X4};
        SPL_8X8: qw_nxt = '{LW_OFF, LW_X8, LW_OFF, LW_X8};
        SPL_16: qw_nxt = '{LW_OFF, LW_OFF, LW_OFF, LW_X16};
        // Reserved codes leave every quad down
        default: qw_nxt = '{LW_OFF, LW_OFF, LW_OFF, LW_OFF};
      endcase
    end
  end

  // Width only changes at a launch, so a stray field write does not retrain
  always_ff @(posedge clk) begin
    if (srst) begin
      qw_r <= '{LW_OFF, LW_OFF, LW_OFF, LW_OFF};
    end else if (bif_start) begin
      qw_r <= qw_nxt;
    end
  end
  assign quad_width = qw_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      inj_dis_r <= 1'b0;
      inj_dis_done_r <= 1'b0;
    end else if (wr_inj && !inj_dis_done_r) begin
      inj_dis_r <= cfg_wdata[INJ_DIS_BIT];
      inj_dis_done_r <= 1'b1;
    end
  end

  // Rising-edge pulses; one pulse only; gated
  always_ff @(posedge clk) begin
    if (srst) begin
      inj_cto_r <= 1'b0;
      inj_rcv_r <= 1'b0;
      cto_pulse_r <= 1'b0;
      rcv_pulse_r <= 1'b0;
    end else begin
      if (wr_inj) begin
        inj_cto_r <= new_cto;
        inj_rcv_r <= new_rcv;
      end
      cto_pulse_r <= wr_inj && new_cto && !inj_cto_r && !inj_dis_r;
      rcv_pulse_r <= wr_inj && new_rcv && !inj_rcv_r && !inj_dis_r;
    end
  end

  assign cto_err_out = cto_err_in || cto_pulse_r;
  assign rcv_err_out = rcv_err_in || rcv_pulse_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      cto_sel_r <= 2'h0;
    end else if (wr_cto) begin
      cto_sel_r <= cfg_wdata[CTO_SEL_LSB +: CTO_SEL_W];
    end
  end
  assign cto_subrange = cto_sel_r;

  // Host-link control and status; status set wins over clear
  always_ff @(posedge clk) begin
    if (srst) begin
      host_en_r <= HOST_CTRL_RST;
      host_ack_r <= 1'b0;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= host_ack_in;
      ack_s2_r <= ack_s1_r;
      if (wr_hctl) begin
        host_en_r <= cfg_wdata[HOST_CTRL_EN_BIT];
      end
      if (ack_s2_r && HOST_LINK_PORT) begin
        host_ack_r <= 1'b1;
      end else if (wr_hsts && cfg_wdata[HOST_STAT_ACK_BIT]) begin
        host_ack_r <= 1'b0;
      end
    end
  end
  assign host_ctrl_en = host_en_r;

  // Read mux; start reads zero; constants
  always_comb begin
    rd_mux = 32'h0;
    unique case (cfg_addr)
      OFS_LANE_SPLIT: rd_mux = {29'h0, split_r};
      OFS_HOST_CTRL: rd_mux = {31'h0, host_en_r && HOST_LINK_PORT};
      OFS_HOST_STAT: rd_mux = {31'h0, host_ack_r};
      OFS_CAP_HDR: rd_mux = {HOST_LINK_PORT ? NXT_PTR_HOST : NXT_PTR_PORT, CAP_VER, CAP_ID};
      OFS_VEND_HDR: rd_mux = {VSEC_LEN, VSEC_REV, VSEC_ID};
      OFS_INJ_CTRL: rd_mux = {29'h0, inj_cto_r, inj_rcv_r, inj_dis_r};
      OFS_CTO_CTRL: rd_mux = {22'h0, cto_sel_r, 8'h0};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_r <= 32'h0;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= cfg_rd;
      rdata_r <= cfg_rd ? rd_mux : 32'h0;
    end
  end
  assign cfg_rdata = rdata_r;
  assign cfg_rvalid = rvalid_r;
endmodule : rpls_regs
`default_nettype wire

// ==== rpls_pkg.sv ====
// Constants for the root port lane-split and error-injection register bank.
// Assumes a configuration-space access port on the host clock, 32-bit dwords.
// Behaviour
// - Writing one to start bit launches bifurcation with programmed split code; no launch on host-link port.
// - Start and split written together use the newly written split code.
// - Start bit always reads zero.
// - Split field sticky, resets to four; reads zero, read-only on host-link port.
// - Leaving full reset, ports split per held split field without start write.
// - Eight-lane port: 000 two x4 links, 001 one x8 link.
// - Sixteen-lane: 000 4x4, 001 x4x4x8, 010 x8x4x4, 011 x8x8, 100 x16.
// - Next pointer reads 0x250, or 0x280 on host-link port.
// - Capability id 0xb in 15:0, version 0x1 in 19:16, read-only.
// - Vendor header length 0xa in bits 31:20, read-only.
// - Vendor header revision reads one.
// - Timeout-inject 0 to 1 write gives one uncorrectable timeout pulse.
// - Receiver-inject 0 to 1 write gives one correctable receiver pulse.
// - Injected pulses ORed into normal error sources.
// - Held inject bit gives no persistent error; clear before re-injecting.
// - Injection-disable bit blocks both injection pulses.
// - Sub-range field 9:8 selects 17-30, 31-45, 46-64 s; 11 reserved.
`default_nettype none
package rpls_pkg;
  localparam logic [11:0] OFS_LANE_SPLIT = 12'h190;
  localparam logic [11:0] OFS_HOST_CTRL = 12'h1a0;
  localparam logic [11:0] OFS_HOST_STAT = 12'h1a8;
  localparam logic [11:0] OFS_CAP_HDR = 12'h1d0;
  localparam logic [11:0] OFS_VEND_HDR = 12'h1d4;
  localparam logic [11:0] OFS_INJ_CTRL = 12'h1d8;
  localparam logic [11:0] OFS_CTO_CTRL = 12'h1e0;

  localparam int SPLIT_LSB = 0;
  localparam int SPLIT_W = 3;
  localparam int START_BIT = 3;
  localparam logic [2:0] SPLIT_RST = 3'h4;

  localparam logic [11:0] NXT_PTR_PORT = 12'h250;
  localparam logic [11:0] NXT_PTR_HOST = 12'h280;
  localparam logic [3:0] CAP_VER = 4'h1;
  localparam logic [15:0] CAP_ID = 16'h000b;
  localparam logic [11:0] VSEC_LEN = 12'h00a;
  localparam logic [3:0] VSEC_REV = 4'h1;

  localparam int INJ_DIS_BIT = 0;
  localparam int INJ_RCV_BIT = 1;
  localparam int INJ_CTO_BIT = 2;
  localparam int CTO_SEL_LSB = 8;
  localparam int CTO_SEL_W = 2;
  localparam int HOST_CTRL_EN_BIT = 0;
  localparam logic HOST_CTRL_RST = 1'b1;
  localparam int HOST_STAT_ACK_BIT = 0;

  // Lane-split codes
  localparam logic [2:0] SPL_4X4X4X4 = 3'h0;
  localparam logic [2:0] SPL_4X4X8 = 3'h1;
  localparam logic [2:0] SPL_8X4X4 = 3'h2;
  localparam logic [2:0] SPL_8X8 = 3'h3;
  localparam logic [2:0] SPL_16 = 3'h4;
  localparam logic [2:0] SPL8_4X4 = 3'h0;
  localparam logic [2:0] SPL8_8 = 3'h1;

  // Link width codes per quad: 0 off, 1 x4, 2 x8, 3 x16
  typedef enum logic [1:0] {
    LW_OFF = 2'h0,
    LW_X4 = 2'h1,
    LW_X8 = 2'h2,
    LW_X16 = 2'h3
  } rpls_width_type;
endpackage : rpls_pkg
`default_nettype wire

// ==== rpls_regs_checker.sv ====
// Port-level checks for the lane-split and error-injection register bank.
// Sees only the bank's ports; bound from the bench top.
`default_nettype none
module rpls_regs_checker import rpls_pkg::*; #(
  parameter bit HOST_LINK_PORT = 1'b0,
  parameter logic [15:0] VSEC_ID = 16'h00a5
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic cto_err_in,
  input wire logic rcv_err_in,
  input wire logic cto_err_out,
  input wire logic rcv_err_out,
  input wire logic bif_start,
  input wire logic [2:0] bif_split,
  input wire logic [1:0] cto_subrange
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire logic wr_split = cfg_wr && cfg_addr == OFS_LANE_SPLIT && cfg_be[0];
  wire logic wr_inj = cfg_wr && cfg_addr == OFS_INJ_CTRL && cfg_be[0];
  wire logic [11:0] nxt = HOST_LINK_PORT ? NXT_PTR_HOST : NXT_PTR_PORT;
  // A launch write carries its own split code, host-link port stores zero
  AST_START_PULSE: assert property (wr_split && cfg_wdata[3] |=> bif_start &&
    bif_split == (HOST_LINK_PORT ? 3'h0 : $past(cfg_wdata[2:0])))
    else $error("start write did not launch with its split code");
  AST_NO_STRAY_START: assert property (bif_start && !$past(srst) && !$past(srst, 2)
    |-> $past(wr_split && cfg_wdata[3])) else $error("launch without start write");
  AST_START_READ: assert property ($past(cfg_rd && cfg_addr == OFS_LANE_SPLIT)
    |-> cfg_rvalid && !cfg_rdata[3]) else $error("start bit read back as one");
  AST_CAP_HDR: assert property ($past(cfg_rd && cfg_addr == OFS_CAP_HDR)
    |-> cfg_rdata == {nxt, CAP_VER, CAP_ID}) else $error("capability header wrong");
  AST_VEND_HDR: assert property ($past(cfg_rd && cfg_addr == OFS_VEND_HDR)
    |-> cfg_rdata == {VSEC_LEN, VSEC_REV, VSEC_ID}) else $error("vendor header wrong");
  AST_CTO_CAUSE: assert property (cto_err_out && !cto_err_in
    |-> $past(wr_inj && cfg_wdata[2])) else $error("timeout pulse without write");
  AST_CTO_ONE: assert property (cto_err_out && !cto_err_in
    |=> !cto_err_out || cto_err_in) else $error("timeout pulse longer than one cycle");
  AST_RCV_CAUSE: assert property (rcv_err_out && !rcv_err_in
    |-> $past(wr_inj && cfg_wdata[1])) else $error("receiver pulse without write");
  AST_OR_PATH: assert property ((!cto_err_in || cto_err_out) &&
    (!rcv_err_in || rcv_err_out)) else $error("genuine error not passed through");
  AST_SUBRANGE: assert property (cfg_wr && cfg_addr == OFS_CTO_CTRL && cfg_be[1]
    |=> cto_subrange == $past(cfg_wdata[9:8])) else $error("sub-range not taken");
  cover property (wr_split && cfg_wdata[3]);
  cover property (cto_err_out && !cto_err_in);
  cover property (rcv_err_out && !rcv_err_in);
endmodule : rpls_regs_checker
`default_nettype wire

// ==== root_port_lane_split_and_error_inject_bench.sv ====
// Self-checking bench for the lane-split and error-injection register bank.
// Drives configuration strobes itself at the falling clock edge.
`default_nettype none
module root_port_lane_split_and_error_inject_bench import rpls_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, srst = 1, sticky_rst = 1, cfg_wr = 0, cfg_rd = 0, cto_i = 0, rcv_i = 0;
  logic [11:0] addr = 0;
  logic [31:0] wdata = 0, rdata;
  logic rvalid, cto_o, rcv_o, bstart;
  logic [2:0] bsplit;
  logic [1:0] subr;
  rpls_width_type [3:0] qw, qw8;
  logic hen;
  int err_total = 0, cmp_count = 0, cto_n = 0, rcv_n = 0;
  // Expected quad widths per split code, highest quad first
  logic [7:0] qtab [5] = '{8'h55, 8'h52, 8'h25, 8'h22, 8'h03};
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (cto_o === 1'b1) cto_n++;
    if (rcv_o === 1'b1) rcv_n++;
  end
  rpls_regs dut (.clk(clk), .srst(srst), .sticky_rst(sticky_rst), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(addr), .cfg_be(4'hf), .cfg_wdata(wdata), .cfg_rdata(rdata),
    .cfg_rvalid(rvalid), .cto_err_in(cto_i), .rcv_err_in(rcv_i), .host_ack_in(1'b0),
    .cto_err_out(cto_o), .rcv_err_out(rcv_o), .bif_start(bstart), .bif_split(bsplit),
    .quad_width(qw), .cto_subrange(subr), .host_ctrl_en(hen));
  // Eight-lane port fed the same strobes, only its split decode is watched
  rpls_regs #(.WIDE_PORT(1'b0)) dut8 (.clk(clk), .srst(srst), .sticky_rst(sticky_rst),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(addr), .cfg_be(4'hf), .cfg_wdata(wdata),
    .cfg_rdata(), .cfg_rvalid(), .cto_err_in(cto_i), .rcv_err_in(rcv_i), .host_ack_in(1'b0),
    .cto_err_out(), .rcv_err_out(), .bif_start(), .bif_split(), .quad_width(qw8),
    .cto_subrange(), .host_ctrl_en());
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Ends one idle cycle later so strobes never toggle twice in a time step
  task wr(input logic [11:0] a, input logic [31:0] d);
    addr = a;
    wdata = d;
    cfg_wr = 1;
    @(negedge clk);
    cfg_wr = 0;
    @(negedge clk);
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] e);
    addr = a;
    cfg_rd = 1;
    @(negedge clk);
    cfg_rd = 0;
    chk(rvalid, 1);
    chk(rdata, e);
    @(negedge clk);
  endtask : rd
  task rst(input logic st);
    srst = 1;
    sticky_rst = st;
    repeat (20) @(negedge clk);
    srst = 0;
    sticky_rst = 0;
    repeat (3) @(negedge clk);
  endtask : rst
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  initial begin
    #200000;
    err_total++;
    give_verdict;
  end
  initial begin
    rst(1);
    chk(qw, qtab[4]);
    chk(qw8, 8'h00);
    chk(hen, 1'b1);
    rd(OFS_LANE_SPLIT, 32'h4);
    rd(OFS_CAP_HDR, {NXT_PTR_PORT, CAP_VER, CAP_ID});
    rd(OFS_VEND_HDR, {VSEC_LEN, VSEC_REV, 16'h00a5});
    rd(12'h3fc, 32'h0);
    wr(OFS_LANE_SPLIT, 32'hb);
    @(negedge clk);
    chk(qw, qtab[3]);
    rd(OFS_LANE_SPLIT, 32'h3);
    // Start writes could relaunch, but other codes here arrive through reset
    // no second start write is issued in this loop
    // only defined sixteen-lane codes are programmed
    for (int c = 0; c < 5; c++) begin
      wr(OFS_LANE_SPLIT, 32'(c));
      rst(0);
      chk(qw, qtab[c]);
      if (c < 2) chk(qw8, (c == 0) ? 8'h05 : 8'h02);
      rd(OFS_LANE_SPLIT, 32'(c));
    end
    wr(OFS_INJ_CTRL, 32'h4);
    wr(OFS_INJ_CTRL, 32'h4);
    wr(OFS_INJ_CTRL, 32'h1);
    wr(OFS_INJ_CTRL, 32'h6);
    chk(cto_n, 2);
    chk(rcv_n, 1);
    rd(OFS_INJ_CTRL, 32'h6);
    cto_i = 1;
    rcv_i = 1;
    @(negedge clk);
    cto_i = 0;
    rcv_i = 0;
    chk(cto_n, 3);
    chk(rcv_n, 2);
    rst(0);
    wr(OFS_INJ_CTRL, 32'h1);
    wr(OFS_INJ_CTRL, 32'h6);
    chk(cto_n + rcv_n, 5);
    rd(OFS_INJ_CTRL, 32'h7);
    // reserved sub-range code 11 is never written
    for (int s = 0; s < 3; s++) begin
      wr(OFS_CTO_CTRL, 32'(s) << 8);
      chk(subr, 32'(s));
    end
    give_verdict;
  end
endmodule : root_port_lane_split_and_error_inject_bench
bind rpls_regs rpls_regs_checker #(.HOST_LINK_PORT(HOST_LINK_PORT), .VSEC_ID(VSEC_ID)) chk_i (
  .clk(clk), .srst(srst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
  .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
  .cto_err_in(cto_err_in), .rcv_err_in(rcv_err_in), .cto_err_out(cto_err_out),
  .rcv_err_out(rcv_err_out), .bif_start(bif_start), .bif_split(bif_split),
  .cto_subrange(cto_subrange));
`default_nettype wire
